// file: lme_pkg.sv
// Shared constants for the literal and indirect move execution block
package lme_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction word layout
  localparam int unsigned LME_IW = 14;
  localparam int unsigned LME_OP_MSB = 13;
  localparam int unsigned LME_OP_LSB = 11;
  localparam logic [2:0] LME_OP_LIT_PCH = 3'h1;
  localparam logic [2:0] LME_OP_LIT_ACC = 3'h2;
  localparam logic [2:0] LME_OP_ST_DIR = 3'h3;
  localparam logic [2:0] LME_OP_ST_IND = 3'h4;
  localparam logic [2:0] LME_OP_ST_REL = 3'h5;
  localparam int unsigned LME_IND_SEL_BIT = 2;
  localparam int unsigned LME_REL_SEL_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned LME_PCH_W = 7;
  localparam int unsigned LME_ACC_W = 8;
  localparam int unsigned LME_FILE_W = 7;
  localparam int unsigned LME_OFS_W = 6;
  localparam int unsigned LME_PTR_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Indirect mode codes
  localparam logic [1:0] LME_MODE_PRE_INC = 2'h0;
  localparam logic [1:0] LME_MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] LME_MODE_POST_INC = 2'h2;
  localparam logic [1:0] LME_MODE_POST_DEC = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Indirect window file addresses
  localparam logic [6:0] LME_WIN0_ADDR = 7'h00;
  localparam logic [6:0] LME_WIN1_ADDR = 7'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [6:0] LME_PCH_RST = 7'h00;
  localparam logic [7:0] LME_ACC_RST = 8'h00;
  localparam logic [15:0] LME_PTR_RST = 16'h0000;

  typedef enum logic [2:0] {
    LME_K_NONE,
    LME_K_LIT_PCH,
    LME_K_LIT_ACC,
    LME_K_ST_DIR,
    LME_K_ST_IND,
    LME_K_ST_REL
  } lme_kind_e;

endpackage

// file: lme_addr_unit.sv
// Effective address and pointer update for the indirect store
`timescale 1ns/1ps
`default_nettype none
module lme_addr_unit import lme_pkg::*; #(
  parameter int unsigned PW = LME_PTR_W
) (
  input wire logic [PW-1:0] i_ptr,
  input wire logic i_rel,
  input wire logic [1:0] i_mode,
  input wire logic [LME_OFS_W-1:0] i_offset,
  output logic [PW-1:0] o_addr,
  output logic [PW-1:0] o_ptr_next
);

  logic [PW-1:0] inc;
  logic [PW-1:0] dec;
  logic [PW-1:0] rel;

  // carry is dropped, no flag output exists
  assign inc = i_ptr + PW'(1);
  assign dec = i_ptr - PW'(1);
  assign rel = i_ptr + {{(PW-LME_OFS_W){i_offset[LME_OFS_W-1]}}, i_offset};

  always_comb begin
    o_addr = i_ptr;
    o_ptr_next = i_ptr;
    if (i_rel) begin
      o_addr = rel;
      o_ptr_next = i_ptr;
    end else begin
      case (i_mode)
        LME_MODE_PRE_INC: begin
          o_addr = inc;
          o_ptr_next = inc;
        end
        LME_MODE_PRE_DEC: begin
          o_addr = dec;
          o_ptr_next = dec;
        end
        LME_MODE_POST_INC: begin
          o_addr = i_ptr;
          o_ptr_next = inc;
        end
        LME_MODE_POST_DEC: begin
          o_addr = i_ptr;
          o_ptr_next = dec;
        end
        default: begin
          o_addr = i_ptr;
          o_ptr_next = i_ptr;
        end
      endcase
    end
  end

endmodule // lme_addr_unit
`default_nettype wire

// file: lme_move_exec.sv
// Literal, direct and indirect move execution for the core
// How it works
// - Literal-to-PC-high loads the seven-bit literal into the PC high latch.
// - Literal-to-accumulator loads the eight-bit literal; flags stay untouched.
// - Accumulator-to-file writes the accumulator to the seven-bit file address, no flags.
// - Indirect store writes the accumulator through one of two pointers.
// - Pre modes adjust the pointer then store; post modes store then adjust.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Relative form stores at pointer plus signed offset; pointer stays unchanged.
// - Indirect windows hold nothing; accesses go to the pointer's address.
// - Pointers are 16 bits and wrap modulo 65536.
// - Pointer arithmetic never sets or clears status flags.
`timescale 1ns/1ps
`default_nettype none
module lme_move_exec import lme_pkg::*; #(
  parameter int unsigned PW = LME_PTR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_valid,
  input wire logic [LME_IW-1:0] i_instr,
  input wire logic i_ptr_wr,
  input wire logic i_ptr_wsel,
  input wire logic [PW-1:0] i_ptr_wdata,
  input wire logic [LME_FILE_W-1:0] i_rd_file_addr,
  output logic [PW-1:0] o_rd_mem_addr,
  output logic [LME_PCH_W-1:0] o_pc_high_q,
  output logic [LME_ACC_W-1:0] o_acc_q,
  output logic [PW-1:0] o_ptr0_q,
  output logic [PW-1:0] o_ptr1_q,
  output logic o_mem_we_q,
  output logic [PW-1:0] o_mem_addr_q,
  output logic [LME_ACC_W-1:0] o_mem_wdata_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  lme_kind_e kind;
  logic [2:0] opcode;
  logic ind_sel;
  logic [PW-1:0] cur_ptr;
  logic [PW-1:0] eff_addr;
  logic [PW-1:0] ptr_next;
  logic [LME_FILE_W-1:0] file_addr;
  logic dir_hit;
  logic [PW-1:0] dir_addr;
  logic [1:0][PW-1:0] ptr_q;

  assign opcode = i_instr[LME_OP_MSB:LME_OP_LSB];
  assign file_addr = i_instr[LME_FILE_W-1:0];

  always_comb begin
    kind = LME_K_NONE;
    if (i_instr_valid) begin
      case (opcode)
        LME_OP_LIT_PCH: kind = LME_K_LIT_PCH;
        LME_OP_LIT_ACC: kind = LME_K_LIT_ACC;
        LME_OP_ST_DIR: kind = LME_K_ST_DIR;
        LME_OP_ST_IND: kind = LME_K_ST_IND;
        LME_OP_ST_REL: kind = LME_K_ST_REL;
        default: kind = LME_K_NONE;
      endcase
    end
  end

  assign ind_sel = (opcode == LME_OP_ST_REL) ? i_instr[LME_REL_SEL_BIT] : i_instr[LME_IND_SEL_BIT];
  assign cur_ptr = ptr_q[ind_sel];

  lme_addr_unit #(.PW(PW)) u_addr (
    .i_ptr(cur_ptr),
    .i_rel(opcode == LME_OP_ST_REL),
    .i_mode(i_instr[1:0]),
    .i_offset(i_instr[LME_OFS_W-1:0]),
    .o_addr(eff_addr),
    .o_ptr_next(ptr_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Window redirect
  // window maps to pointer
  assign dir_hit = (file_addr == LME_WIN0_ADDR) || (file_addr == LME_WIN1_ADDR);
  assign dir_addr = (file_addr == LME_WIN0_ADDR) ? ptr_q[0] :
                    (file_addr == LME_WIN1_ADDR) ? ptr_q[1] : PW'(file_addr);
  assign o_rd_mem_addr = (i_rd_file_addr == LME_WIN0_ADDR) ? ptr_q[0] :
                         (i_rd_file_addr == LME_WIN1_ADDR) ? ptr_q[1] : PW'(i_rd_file_addr);

  ////////////////////////////////////////////////////////////////////////////
  // Architectural registers
  // PC high latch load
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pc_high_q <= LME_PCH_RST;
    end else if (kind == LME_K_LIT_PCH) begin
      o_pc_high_q <= i_instr[LME_PCH_W-1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_acc_q <= LME_ACC_RST;
    end else if (kind == LME_K_LIT_ACC) begin
      o_acc_q <= i_instr[LME_ACC_W-1:0];
    end
  end

  // pointer update, instruction beats external write
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ptr_q <= {2{LME_PTR_RST}};
    end else if (kind == LME_K_ST_IND) begin
      ptr_q[ind_sel] <= ptr_next;
    end else if (i_ptr_wr) begin
      ptr_q[i_ptr_wsel] <= i_ptr_wdata;
    end
  end

  assign o_ptr0_q = ptr_q[0];
  assign o_ptr1_q = ptr_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Memory write port
  // one cycle per move
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_mem_we_q <= 1'b0;
      o_mem_addr_q <= LME_PTR_RST;
      o_mem_wdata_q <= LME_ACC_RST;
    end else begin
      o_mem_we_q <= 1'b0;
      case (kind)
        LME_K_ST_DIR: begin
          o_mem_we_q <= 1'b1;
          o_mem_addr_q <= dir_addr;
          o_mem_wdata_q <= o_acc_q;
        end
        LME_K_ST_IND, LME_K_ST_REL: begin
          o_mem_we_q <= 1'b1;
          o_mem_addr_q <= eff_addr;
          o_mem_wdata_q <= o_acc_q;
        end
        default: begin
          o_mem_we_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  pch_load_a: assert property (kind == LME_K_LIT_PCH |=> o_pc_high_q == $past(i_instr[6:0]))
    else $error("pc high latch not loaded");
  acc_load_a: assert property (kind == LME_K_LIT_ACC |=> o_acc_q == $past(i_instr[7:0]) && !o_mem_we_q)
    else $error("accumulator literal not loaded");
  dir_store_a: assert property (kind == LME_K_ST_DIR && !dir_hit |=>
    o_mem_we_q && o_mem_addr_q == PW'($past(file_addr)) && o_mem_wdata_q == $past(o_acc_q))
    else $error("direct store wrong");
  pre_mode_a: assert property (kind == LME_K_ST_IND && !i_instr[1] |=>
    o_mem_we_q && o_mem_addr_q == ($past(ind_sel) ? o_ptr1_q : o_ptr0_q))
    else $error("pre mode address not updated pointer");
  post_mode_a: assert property (kind == LME_K_ST_IND && i_instr[1] |=>
    o_mem_addr_q == $past(cur_ptr) &&
    ($past(ind_sel) ? o_ptr1_q : o_ptr0_q) == ($past(i_instr[0]) ? $past(cur_ptr) - PW'(1) : $past(cur_ptr) + PW'(1)))
    else $error("post mode store or adjust wrong");
  rel_keep_a: assert property (kind == LME_K_ST_REL && !i_ptr_wr |=>
    $stable(o_ptr0_q) && $stable(o_ptr1_q) &&
    o_mem_addr_q == $past(cur_ptr) + {{(PW-6){$past(i_instr[5])}}, $past(i_instr[5:0])})
    else $error("relative store wrong or pointer moved");
  ptr_wrap_a: assert property (kind == LME_K_ST_IND && i_instr[1:0] == LME_MODE_PRE_INC && cur_ptr == 16'hffff |=>
    o_mem_addr_q == 16'h0000)
    else $error("pointer did not wrap");
  win_read_a: assert property (i_rd_file_addr == LME_WIN1_ADDR |-> o_rd_mem_addr == o_ptr1_q)
    else $error("window read not redirected");
  we_cause_a: assert property (o_mem_we_q |-> $past(kind == LME_K_ST_DIR || kind == LME_K_ST_IND || kind == LME_K_ST_REL))
    else $error("store pulse without store");

  pre_dec_c: cover property (kind == LME_K_ST_IND && i_instr[1:0] == LME_MODE_PRE_DEC);
  rel_neg_c: cover property (kind == LME_K_ST_REL && i_instr[5]);
  win_store_c: cover property (kind == LME_K_ST_DIR && dir_hit);
  back_to_back_c: cover property (kind == LME_K_LIT_ACC ##1 kind == LME_K_ST_IND);

endmodule // lme_move_exec
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the literal and indirect move block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  import lme_pkg::*;
  logic clk, rst, vld, pwr, psel;
  logic [13:0] ins;
  logic [15:0] pdat, rdaddr, p0, p1, maddr;
  logic [6:0] rdf, pch;
  logic [7:0] acc, wdat;
  logic we;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  lme_move_exec dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_instr_valid(vld), .i_instr(ins),
    .i_ptr_wr(pwr), .i_ptr_wsel(psel), .i_ptr_wdata(pdat), .i_rd_file_addr(rdf),
    .o_rd_mem_addr(rdaddr), .o_pc_high_q(pch), .o_acc_q(acc), .o_ptr0_q(p0), .o_ptr1_q(p1),
    .o_mem_we_q(we), .o_mem_addr_q(maddr), .o_mem_wdata_q(wdat));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Bounds a hung run; the whole sequence needs well under 300 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Called at a falling edge; returns one cycle later with the result settled
  task automatic exec(input logic [13:0] w);
    vld = 1'b1;
    ins = w;
    @(negedge clk);
    vld = 1'b0;
    ins = 14'h0000;
  endtask
  task automatic setp(input logic s, input logic [15:0] d);
    pwr = 1'b1;
    psel = s;
    pdat = d;
    @(negedge clk);
    pwr = 1'b0;
  endtask
  task automatic t_lit();
    exec({LME_OP_LIT_PCH, 4'h0, 7'h7f});
    `CHK(pch, 7'h7f)
    `CHK(acc, 8'h00)
    exec({LME_OP_LIT_PCH, 4'hf, 7'h00});
    `CHK(pch, 7'h00)
    exec({LME_OP_LIT_ACC, 3'h0, 8'hff});
    `CHK(acc, 8'hff)
    `CHK(pch, 7'h00)
    `CHK(we, 1'b0)
  endtask
  task automatic t_direct();
    setp(1'b0, 16'h1234);
    // Load then store back to back: the store must see the new value
    vld = 1'b1;
    ins = {LME_OP_LIT_ACC, 3'h0, 8'ha5};
    @(negedge clk);
    ins = {LME_OP_ST_DIR, 4'h0, 7'h7f};
    @(negedge clk);
    vld = 1'b0;
    `CHK({we, maddr, wdat}, {1'b1, 16'h007f, 8'ha5})
    @(negedge clk);
    `CHK(we, 1'b0)
    exec({LME_OP_ST_DIR, 4'h0, LME_WIN0_ADDR});
    `CHK({we, maddr}, {1'b1, 16'h1234})
    rdf = LME_WIN0_ADDR;
    #1 `CHK(rdaddr, 16'h1234)
    rdf = 7'h55;
    #1 `CHK(rdaddr, 16'h0055)
  endtask
  task automatic t_modes();
    logic [15:0] base, nxt, ea;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        base = m[0] ? 16'h0000 : 16'hffff;
        nxt = m[0] ? 16'hffff : 16'h0000;
        ea = m[1] ? base : nxt;
        setp(s[0], base);
        exec({LME_OP_ST_IND, 8'h00, s[0], m[1:0]});
        `CHK({we, maddr, wdat}, {1'b1, ea, 8'ha5})
        `CHK(s[0] ? p1 : p0, nxt)
      end
    end
  endtask
  task automatic t_rel();
    setp(1'b1, 16'h0010);
    exec({LME_OP_ST_REL, 4'h0, 1'b1, 6'h20});
    `CHK({we, maddr, p1}, {1'b1, 16'hfff0, 16'h0010})
    exec({LME_OP_ST_REL, 4'h0, 1'b1, 6'h1f});
    `CHK({maddr, p1}, {16'h002f, 16'h0010})
    setp(1'b0, 16'hffff);
    exec({LME_OP_ST_REL, 4'h0, 1'b0, 6'h01});
    `CHK({maddr, p0}, {16'h0000, 16'hffff})
  endtask
  task automatic t_clash();
    setp(1'b0, 16'h0100);
    pwr = 1'b1;
    psel = 1'b0;
    pdat = 16'hbeef;
    exec({LME_OP_ST_IND, 8'h00, 1'b0, LME_MODE_POST_INC});
    `CHK({maddr, p0}, {16'h0100, 16'h0101})
    psel = 1'b1;
    pdat = 16'h4321;
    exec({LME_OP_ST_REL, 4'h0, 1'b0, 6'h02});
    pwr = 1'b0;
    `CHK({maddr, p0, p1}, {16'h0103, 16'h0101, 16'h4321})
  endtask
  task automatic t_ignore();
    exec({3'h7, 11'h0ff});
    `CHK({we, acc, pch}, {1'b0, 8'ha5, 7'h00})
    exec({3'h0, 11'h011});
    `CHK({we, acc}, {1'b0, 8'ha5})
    ins = {LME_OP_LIT_ACC, 3'h0, 8'h3c};
    @(negedge clk);
    `CHK(acc, 8'ha5)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    vld = 1'b0;
    ins = 14'h0000;
    pwr = 1'b0;
    psel = 1'b0;
    pdat = 16'h0000;
    rdf = 7'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    `CHK({pch, acc, p0, p1, we, maddr, wdat}, 58'h0)
    t_lit();
    t_direct();
    t_modes();
    t_rel();
    t_clash();
    t_ignore();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
